//--- hdl/ppn_norm_if.sv
`timescale 1ns/1ns
`default_nettype none
interface ppn_norm_if
  import ppn_pkg::*;
();
  logic [XW-1:0] x_in;
  logic [SHW-1:0] shift_code;
  logic [XW-1:0] result;
  logic round_bit;
  logic zeroed;
  modport norm_side (input x_in, shift_code, output result, round_bit, zeroed);
  modport user_side (output x_in, shift_code, input result, round_bit, zeroed);
endinterface
`default_nettype wire

//--- hdl/ppn_normaliser.sv
`timescale 1ns/1ns
`default_nettype none
module ppn_normaliser
  import ppn_pkg::*;
(
  ppn_norm_if.norm_side nif
);
  logic signed [XW:0] ext;
  logic [SHW-1:0] lamt;

  // code is signed: 0..14 right, 30/31 left by 2/1, the rest zeroes
  always_comb
  begin
    ext = $signed({nif.x_in, 1'b0}) >>> nif.shift_code;
    lamt = 5'h00 - nif.shift_code;
    nif.result = '0;
    nif.round_bit = 1'b0;
    nif.zeroed = 1'b0;
    if (nif.shift_code <= SH_RIGHT_MAX)
    begin
      nif.result = ext[XW:1];
      nif.round_bit = ext[0];
    end
    else if (nif.shift_code >= SH_LEFT_MIN)
    begin
      // left overflow is not detected, unlike the prescaler, which flags over/underselect
      nif.result = nif.x_in << lamt;
    end
    else
    begin
      nif.zeroed = 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- hdl/ppn_pkg.sv
`default_nettype none
package ppn_pkg;
  localparam int XW = 22;
  localparam int FW = 8;
  localparam int TW = 32;
  localparam int TDEPTH = 64;
  localparam int SHW = 5;
  localparam int AW = 12;
  localparam int CW = 8;
  // register byte offsets
  localparam logic [AW-1:0] OFS_SIGN_CFG = 12'h000;
  localparam logic [AW-1:0] OFS_ACCESS = 12'h004;
  localparam logic [AW-1:0] OFS_OUTSEL = 12'h008;
  localparam logic [AW-1:0] OFS_NORM = 12'h00c;
  localparam logic [AW-1:0] OFS_STATUS = 12'h010;
  localparam logic [AW-1:0] OFS_TABLE_BASE = 12'h100;
  localparam logic [AW-1:0] OFS_TABLE_END = 12'h200;
  localparam logic [AW-1:0] OFS_UPPER_SAT = 12'h200;
  localparam logic [AW-1:0] OFS_LOWER_SAT = 12'h204;
  // field positions
  localparam int POS_LSB = 0;
  localparam int POS_W = 5;
  localparam int UNSIGNED_BIT = 6;
  localparam int ACCESS_BIT = 1;
  localparam int ROUTE_HI_BIT = 5;
  localparam int ROUTE_LO_BIT = 6;
  localparam int SHIFT_LSB = 3;
  localparam int DYN_BIT = 2;
  localparam int ADD_Y_BIT = 1;
  localparam int YSHIFT_LSB = 22;
  localparam int ST_OVER_BIT = 0;
  localparam int ST_UNDER_BIT = 1;
  localparam int ST_POVF_BIT = 2;
  localparam int ST_NOVF_BIT = 3;
  localparam int ST_ACCESS_BIT = 4;
  // reset values
  localparam logic [CW-1:0] RST_SIGN_CFG = 8'h00;
  localparam logic [CW-1:0] RST_ACCESS = 8'h00;
  localparam logic [CW-1:0] RST_OUTSEL = 8'h00;
  localparam logic [CW-1:0] RST_NORM = 8'h00;
  localparam logic [TW-1:0] RST_WORD = 32'h00000000;
  // limits
  localparam logic [POS_W-1:0] MAX_POS = 5'h0e;
  localparam logic [SHW-1:0] SH_RIGHT_MAX = 5'h0e;
  localparam logic [SHW-1:0] SH_LEFT_MIN = 5'h1e;
  localparam logic [1:0] BYTE_MSB_SEL = 2'h3;
  localparam logic [XW:0] SUM_MAX = 23'h1fffff;
  localparam logic [XW:0] SUM_MIN = 23'h600000;
endpackage
`default_nettype wire

//--- hdl/ppn_top.sv
// Contract
// - prescaler picks any 8-bit field of input
// - signedness bit zero: signed address, else unsigned
// - flag over/underselect when field misses significance
// - table of 64 words plus two saturation words
// - top six bits pick word, low two byte
// - overflow or misselect forces a saturation word
// - saturation forces most significant byte out
// - table addresses map one-to-one onto field values
// - access bit zero: processor owns table, bus zero
// - normaliser shifts right 14, left 2
// - out-of-range shift zeroes normaliser output
// - shift from control field or word bits 26:22
// - adder sums normaliser, round and optional word
// - route selected byte to upper or lower output
// - other output bits come from the adder
// - flag overflow beyond signed 22-bit range
// - input bus is the rectifier output
`timescale 1ns/1ns
`default_nettype none
module ppn_top
  import ppn_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [AW-1:0] reg_addr,
  input wire logic [TW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [TW-1:0] reg_rdata,
  input wire logic [XW-1:0] x_bus,
  input wire logic [XW:0] cascade_sum,
  output logic [XW-1:0] casc_out,
  output logic [FW-1:0] byte_out,
  output logic sel_over,
  output logic sel_under
);
  logic [CW-1:0] address_signedness_config_reg;
  logic [CW-1:0] table_access_control_reg;
  logic [CW-1:0] output_select_control_reg;
  logic [CW-1:0] normaliser_control_reg;
  logic [TW-1:0] upper_saturation_word;
  logic [TW-1:0] lower_saturation_word;
  logic [TW-1:0] table_mem [TDEPTH];
  logic [TW-1:0] rdata_reg;
  logic [TW-1:0] rdata_next;
  logic [XW-1:0] casc_reg;
  logic [XW-1:0] casc_next;
  logic [FW-1:0] byte_reg;
  logic over_reg;
  logic under_reg;
  logic povf_reg;
  logic novf_reg;

  logic access;
  logic signed_mode;
  logic [POS_W-1:0] pos_c;
  logic [FW-1:0] field;
  logic [XW-1:0] up_s;
  logic [XW-1:0] up_u;
  logic fits;
  logic over_c;
  logic under_c;
  logic povf_c;
  logic novf_c;
  logic sat_hi;
  logic sat_lo;
  logic [TW-1:0] word_c;
  logic [TW-1:0] y_bus;
  logic [1:0] bsel;
  logic [FW-1:0] byte_c;
  logic [XW-1:0] sum_c;
  logic route_lo;
  logic route_hi;
  logic wr_table;
  logic [5:0] wr_idx;
  logic [FW-1:0] plain_byte_c;

  ppn_norm_if nif ();

  ppn_normaliser u_norm (
    .nif(nif.norm_side)
  );

  function automatic logic [FW-1:0] pick_byte(input logic [TW-1:0] w,
                                              input logic [1:0] s);
    pick_byte = w[s*FW +: FW];
  endfunction

  function automatic logic table_hit(input logic [AW-1:0] a);
    table_hit = (a >= OFS_TABLE_BASE) && (a < OFS_TABLE_END) &&
                (a[1:0] == 2'h0);
  endfunction

  function automatic logic [5:0] table_idx(input logic [AW-1:0] a);
    logic [AW-1:0] d;
    d = a - OFS_TABLE_BASE;
    table_idx = d[7:2];
  endfunction

  assign access = table_access_control_reg[ACCESS_BIT];
  assign signed_mode = !address_signedness_config_reg[UNSIGNED_BIT];

  // prescaler and select detector; x_bus is the rectifier output
  always_comb
  begin
    pos_c = address_signedness_config_reg[POS_LSB +: POS_W];
    if (pos_c > MAX_POS)
    begin
      pos_c = MAX_POS;
    end
    field = x_bus[pos_c +: FW];
    up_s = $signed(x_bus) >>> (pos_c + 5'h07);
    up_u = x_bus >> (pos_c + 5'h08);
    // signed field must carry the sign; unsigned field needs x >= 0
    if (signed_mode)
    begin
      fits = (up_s == '0) || (up_s == '1);
    end
    else
    begin
      fits = (up_u == '0) && !x_bus[XW-1];
    end
    over_c = !fits && !x_bus[XW-1];
    under_c = !fits && x_bus[XW-1];
  end

  assign povf_c = $signed(cascade_sum) > $signed(SUM_MAX);
  assign novf_c = $signed(cascade_sum) < $signed(SUM_MIN);

  // positive saturation wins if both kinds somehow appear together
  assign sat_hi = povf_c || over_c;
  assign sat_lo = !sat_hi && (novf_c || under_c);

  always_comb
  begin
    if (sat_hi)
    begin
      word_c = upper_saturation_word;
    end
    else if (sat_lo)
    begin
      word_c = lower_saturation_word;
    end
    else
    begin
      word_c = table_mem[field[FW-1:2]];
    end
  end

  assign y_bus = access ? word_c : '0;
  assign bsel = (sat_hi || sat_lo) ? BYTE_MSB_SEL : field[1:0];
  assign byte_c = pick_byte(y_bus, bsel);
  assign plain_byte_c = pick_byte(table_mem[field[FW-1:2]], field[1:0]);

  assign nif.x_in = x_bus;
  // dynamic shift only once the table is in the data path
  assign nif.shift_code = (access && normaliser_control_reg[DYN_BIT]) ?
    y_bus[YSHIFT_LSB +: SHW] :
    normaliser_control_reg[SHIFT_LSB +: SHW];

  assign sum_c = nif.result + {{(XW-1){1'b0}}, nif.round_bit} +
    (normaliser_control_reg[ADD_Y_BIT] ? y_bus[XW-1:0] : '0);

  assign route_lo = output_select_control_reg[ROUTE_LO_BIT];
  assign route_hi = output_select_control_reg[ROUTE_HI_BIT] && !route_lo;

  always_comb
  begin
    casc_next = sum_c;
    if (route_lo)
    begin
      casc_next[FW-1:0] = byte_c;
    end
    else if (route_hi)
    begin
      casc_next[XW-1 -: FW] = byte_c;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      casc_reg <= '0;
      byte_reg <= '0;
      over_reg <= 1'b0;
      under_reg <= 1'b0;
      povf_reg <= 1'b0;
      novf_reg <= 1'b0;
    end
    else
    begin
      casc_reg <= casc_next;
      byte_reg <= byte_c;
      over_reg <= over_c;
      under_reg <= under_c;
      povf_reg <= povf_c;
      novf_reg <= novf_c;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      address_signedness_config_reg <= RST_SIGN_CFG;
      table_access_control_reg <= RST_ACCESS;
      output_select_control_reg <= RST_OUTSEL;
      normaliser_control_reg <= RST_NORM;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        OFS_SIGN_CFG: address_signedness_config_reg <= reg_wdata[CW-1:0];
        OFS_ACCESS: table_access_control_reg <= reg_wdata[CW-1:0];
        OFS_OUTSEL: output_select_control_reg <= reg_wdata[CW-1:0];
        OFS_NORM: normaliser_control_reg <= reg_wdata[CW-1:0];
        default: ;
      endcase
    end
  end

  // table and saturation words only writable while software owns them
  assign wr_table = reg_wr && !access && table_hit(reg_addr);
  assign wr_idx = table_idx(reg_addr);

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < TDEPTH; i++)
      begin
        table_mem[i] <= RST_WORD;
      end
    end
    else if (wr_table)
    begin
      table_mem[wr_idx] <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      upper_saturation_word <= RST_WORD;
      lower_saturation_word <= RST_WORD;
    end
    else if (reg_wr && !access)
    begin
      if (reg_addr == OFS_UPPER_SAT)
      begin
        upper_saturation_word <= reg_wdata;
      end
      if (reg_addr == OFS_LOWER_SAT)
      begin
        lower_saturation_word <= reg_wdata;
      end
    end
  end

  always_comb
  begin
    rdata_next = '0;
    case (reg_addr)
      OFS_SIGN_CFG: rdata_next[CW-1:0] = address_signedness_config_reg;
      OFS_ACCESS: rdata_next[CW-1:0] = table_access_control_reg;
      OFS_OUTSEL: rdata_next[CW-1:0] = output_select_control_reg;
      OFS_NORM: rdata_next[CW-1:0] = normaliser_control_reg;
      OFS_STATUS:
      begin
        rdata_next[ST_OVER_BIT] = over_reg;
        rdata_next[ST_UNDER_BIT] = under_reg;
        rdata_next[ST_POVF_BIT] = povf_reg;
        rdata_next[ST_NOVF_BIT] = novf_reg;
        rdata_next[ST_ACCESS_BIT] = access;
      end
      OFS_UPPER_SAT: rdata_next = access ? '0 : upper_saturation_word;
      OFS_LOWER_SAT: rdata_next = access ? '0 : lower_saturation_word;
      default:
      begin
        if (table_hit(reg_addr) && !access)
        begin
          rdata_next = table_mem[table_idx(reg_addr)];
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdata_reg <= '0;
    end
    else
    begin
      // read data only in the cycle after the strobe
      rdata_reg <= reg_rd ? rdata_next : '0;
    end
  end

  assign reg_rdata = rdata_reg;
  assign casc_out = casc_reg;
  assign byte_out = byte_reg;
  assign sel_over = over_reg;
  assign sel_under = under_reg;

  AST_SAT_UPPER_BYTE:
  assert property (@(posedge ref_clk) disable iff (!arst_n)
    $past(sat_hi) && $past(access) |->
      byte_out == $past(upper_saturation_word[TW-1 -: FW]))
    else $error("upper saturation byte not on byte output");

  AST_SAT_LOWER_WORD:
  assert property (@(posedge ref_clk) disable iff (!arst_n)
    $past(novf_c) && !$past(sat_hi) && $past(access) |->
      byte_out == $past(lower_saturation_word[TW-1 -: FW]))
    else $error("negative overflow did not select lower saturation");

  AST_PLAIN_LOOKUP:
  assert property (@(posedge ref_clk) disable iff (!arst_n)
    $past(access) && !$past(sat_hi) && !$past(sat_lo) |->
      byte_out == $past(plain_byte_c))
    else $error("byte output differs from addressed table byte");

  AST_ACCESS_ZERO:
  assert property (@(posedge ref_clk) disable iff (!arst_n)
    !$past(access) |-> byte_out == '0)
    else $error("table word bus not zero while software owns table");

  AST_TABLE_LOCKED:
  assert property (@(posedge ref_clk) disable iff (!arst_n)
    reg_wr && access && table_hit(reg_addr) |=>
      table_mem[$past(wr_idx)] == $past(table_mem[wr_idx]))
    else $error("table changed while in the data path");

  AST_OVERSELECT:
  assert property (@(posedge ref_clk) disable iff (!arst_n)
    $past(!signed_mode) && $past(up_u != '0) && !$past(x_bus[XW-1])
      |-> sel_over && !sel_under)
    else $error("overselect missed in unsigned mode");

  AST_POS_OVERFLOW:
  assert property (@(posedge ref_clk) disable iff (!arst_n)
    $signed(cascade_sum) == $signed(SUM_MAX) + 1 |=> povf_reg)
    else $error("positive overflow missed at range limit");

  AST_NINE_RIGHT:
  assert property (@(posedge ref_clk) disable iff (!arst_n)
    nif.shift_code == 5'h09 |->
      nif.result == XW'($signed(x_bus) >>> 9) && !nif.zeroed)
    else $error("code 01001 is not a nine place right shift");

  AST_ZEROING:
  assert property (@(posedge ref_clk) disable iff (!arst_n)
    nif.shift_code > SH_RIGHT_MAX && nif.shift_code < SH_LEFT_MIN |->
      nif.result == '0 && !nif.round_bit)
    else $error("out of range shift not zeroed");

  AST_ROUTE_LOW:
  assert property (@(posedge ref_clk) disable iff (!arst_n)
    $past(route_lo) |-> casc_out[FW-1:0] == byte_out &&
      casc_out[XW-1:FW] == $past(sum_c[XW-1:FW]))
    else $error("lower byte routing wrong");

  AST_ADDER_ONLY:
  assert property (@(posedge ref_clk) disable iff (!arst_n)
    !$past(route_lo) && !$past(route_hi) |-> casc_out == $past(sum_c))
    else $error("output not from adder when no byte routed");

  AST_DYN_SHIFT:
  assert property (@(posedge ref_clk) disable iff (!arst_n)
    access && normaliser_control_reg[DYN_BIT] |->
      nif.shift_code == word_c[YSHIFT_LSB +: SHW])
    else $error("dynamic shift not taken from word bits 26 to 22");
endmodule
`default_nettype wire

//--- sim/ppn_src_model.sv
`timescale 1ns/1ns
`default_nettype none
module ppn_src_model
  import ppn_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [XW-1:0] next_x,
  input wire logic [XW:0] next_sum,
  output logic [XW-1:0] x_bus,
  output logic [XW:0] cascade_sum
);
  // the upstream stage is registered, so a sample lands one edge late
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      x_bus <= '0;
      cascade_sum <= '0;
    end
    else
    begin
      x_bus <= next_x;
      cascade_sum <= next_sum;
    end
  end
endmodule
`default_nettype wire

//--- sim/test_post_processor_lut_normaliser_output.sv
`timescale 1ns/1ns
`default_nettype none
module test_post_processor_lut_normaliser_output
  import ppn_pkg::*;
  ;
  logic ref_clk, arst_n, reg_wr, reg_rd, sel_over, sel_under, acc;
  logic [AW-1:0] reg_addr;
  logic [TW-1:0] reg_wdata, reg_rdata, usat, lsat;
  logic [XW-1:0] next_x, x_bus, casc_out;
  logic [XW:0] next_sum, cascade_sum;
  logic [FW-1:0] byte_out;
  logic [CW-1:0] sc, os, nc;
  logic [TW-1:0] tab [TDEPTH];
  int num_errors = 0;
  int samples_checked = 0;
  int pv[4] = '{0, 5, 14, 31};
  int rv[6] = '{-128, 127, 128, -129, 255, -1};
  int sv[6] = '{2097151, 2097152, -2097152, -2097153, 4194303, -4194304};

  ppn_src_model src (.ref_clk(ref_clk), .arst_n(arst_n), .next_x(next_x),
    .next_sum(next_sum), .x_bus(x_bus), .cascade_sum(cascade_sum));
  ppn_top DUT (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .x_bus(x_bus), .cascade_sum(cascade_sum),
    .casc_out(casc_out), .byte_out(byte_out), .sel_over(sel_over),
    .sel_under(sel_under));

  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [TW-1:0] got, exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // the shadow copy follows the access bit, so refused writes stay out
  task automatic wr(input logic [AW-1:0] a, input logic [TW-1:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    case (a)
      OFS_SIGN_CFG: sc = d[CW-1:0];
      OFS_ACCESS: acc = d[ACCESS_BIT];
      OFS_OUTSEL: os = d[CW-1:0];
      OFS_NORM: nc = d[CW-1:0];
      OFS_UPPER_SAT: if (!acc) usat = d;
      OFS_LOWER_SAT: if (!acc) lsat = d;
      default: if (!acc && a >= OFS_TABLE_BASE && a < OFS_TABLE_END)
        tab[a[7:2]] = d;
    endcase
  endtask

  task automatic rd(input logic [AW-1:0] a, input logic [TW-1:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e, "read");
  endtask

  function automatic logic [TW-1:0] model(input logic [XW-1:0] x,
                                           input logic [XW:0] s);
    logic [4:0] p, c;
    logic [FW-1:0] f, by;
    logic signed [XW-1:0] t, n;
    logic ok, ov, un;
    logic [TW-1:0] y;
    logic [1:0] b;
    logic [XW-1:0] o;
    p = (sc[4:0] > 5'h0e) ? 5'h0e : sc[4:0];
    f = FW'(x >> p);
    t = $signed(x) >>> (p + 7);
    ok = sc[6] ? (!x[21] && (x >> (p + 8)) == '0) : (t == '0 || &t);
    ov = !ok && !x[21];
    un = !ok && x[21];
    y = tab[f[7:2]];
    b = f[1:0];
    if (ov || $signed(s) > 2097151)
    begin
      y = usat;
      b = 2'h3;
    end
    else if (un || $signed(s) < -2097152)
    begin
      y = lsat;
      b = 2'h3;
    end
    if (!acc)
      y = '0;
    by = y[8*b +: 8];
    c = (acc && nc[2]) ? y[26:22] : nc[7:3];
    n = '0;
    if (c <= 5'h0e)
      n = $signed(x) >>> c;
    else if (c >= 5'h1e)
      n = x << (6'h20 - c);
    if (c != 5'h00 && c <= 5'h0e)
      n = n + x[c - 1];
    if (nc[1])
      n = n + y[21:0];
    o = n;
    if (os[6])
      o[7:0] = by;
    else if (os[5])
      o[21:14] = by;
    return {o, by, ov, un};
  endfunction

  task automatic smp(input logic [XW-1:0] x, input logic [XW:0] s);
    logic [TW-1:0] e;
    e = model(x, s);
    @(posedge ref_clk);
    next_x <= x;
    next_sum <= s;
    repeat (2) @(posedge ref_clk);
    #1;
    chk({casc_out, byte_out, sel_over, sel_under}, e, "sample");
  endtask

  initial
  begin
    repeat (30000) @(posedge ref_clk);
    num_errors++;
    tally_and_finish();
  end

  initial
  begin
    arst_n = 1'b0;
    {reg_wr, reg_rd, acc, sc, os, nc, usat, lsat} = '0;
    {reg_addr, reg_wdata, next_x, next_sum} = '0;
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'b1;
    #1;
    chk({casc_out, byte_out, sel_over, sel_under}, '0, "reset");
    rd(OFS_STATUS, '0);
    $display("test reset done");
    for (int i = 0; i < TDEPTH; i++)
      wr(OFS_TABLE_BASE + AW'(4 * i),
        (32'(4 * i) * 32'h01010101 + 32'h03020100) ^ 32'h5a3c5a3c);
    wr(OFS_UPPER_SAT, 32'h9c0f8123);
    wr(OFS_LOWER_SAT, 32'h37c10456);
    rd(OFS_TABLE_BASE + 12'h014, tab[5]);
    rd(OFS_LOWER_SAT, lsat);
    rd(12'h020, '0);
    wr(OFS_STATUS, '1);
    rd(OFS_STATUS, '0);
    wr(OFS_ACCESS, 32'h2);
    rd(OFS_STATUS, 32'h10);
    wr(OFS_TABLE_BASE, '1);
    rd(OFS_TABLE_BASE, '0);
    $display("test registers done");
    wr(OFS_SIGN_CFG, 32'h40);
    wr(OFS_OUTSEL, 32'h60);
    wr(OFS_NORM, '0);
    for (int v = 0; v < 256; v++)
      smp(XW'(v), '0);
    $display("test lookup done");
    for (int m = 0; m < 2; m++)
      foreach (pv[j])
      begin
        wr(OFS_SIGN_CFG, 32'(m * 64 + pv[j]));
        foreach (rv[k])
          smp(XW'(rv[k]) << ((pv[j] > 14) ? 14 : pv[j]), '0);
      end
    wr(OFS_SIGN_CFG, '0);
    foreach (sv[k])
      smp(22'h000005, 23'(sv[k]));
    // last sample was a negative overflow with the table in the path
    rd(OFS_STATUS, 32'h18);
    $display("test saturation done");
    wr(OFS_OUTSEL, '0);
    for (int a = 0; a < 2; a++)
      for (int c = 0; c < 32; c++)
      begin
        wr(OFS_NORM, 32'(c * 8 + a * 2));
        smp(22'h2a5b3c, '0);
        smp(22'h3d0f17, '0);
      end
    $display("test normaliser done");
    wr(OFS_OUTSEL, 32'hffffff20);
    wr(OFS_NORM, 32'h6e);
    for (int m = 1; m >= 0; m--)
    begin
      wr(OFS_ACCESS, 32'(2 * m));
      for (int v = 0; v < 256; v++)
        smp(XW'(v - 128), '0);
    end
    rd(OFS_OUTSEL, 32'h20);
    rd(OFS_NORM, 32'h6e);
    $display("test dynamic done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
